// ===== inc/lpc_pkg.sv
// Purpose: Shared constants for the low power control block
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes:   Offsets, status, event and pin field positions, register reset values and the timer divider live here
`default_nettype none
package lpc_pkg;
   // Register bus geometry
   localparam int          LPC_ADDR_W      = 5;
   localparam int          LPC_DATA_W      = 32;
   localparam int          LPC_BE_W        = 4;
   // Register byte offsets
   localparam logic [4:0]  LPC_OFS_STATUS  = 5'h00;
   localparam logic [4:0]  LPC_OFS_CONTROL = 5'h04;
   localparam logic [4:0]  LPC_OFS_STATE   = 5'h08;
   localparam logic [4:0]  LPC_OFS_IRQ_ST  = 5'h0C;
   localparam logic [4:0]  LPC_OFS_IRQ_MSK = 5'h10;
   localparam logic [4:0]  LPC_OFS_TIMER   = 5'h14;
   // Processor status register fields
   localparam int          LPC_IE_BIT      = 0;
   localparam int          LPC_EXL_BIT     = 1;
   localparam int          LPC_ERL_BIT     = 2;
   localparam int          LPC_IM_LSB      = 8;
   localparam int          LPC_IM_W        = 6;
   localparam int          LPC_RP_BIT      = 27;
   localparam logic [31:0] LPC_STATUS_RST  = 32'h0000_0004;
   localparam logic [31:0] LPC_STATUS_WMSK = 32'h0800_3F07;
   // Control register command bits, each acts on a write of one
   localparam int          LPC_CTL_DBG_RET = 0;
   localparam int          LPC_CTL_EXC_RET = 1;
   // Interrupt status and mask layout
   localparam int          LPC_EV_W        = 4;
   localparam int          LPC_EV_SLEEP    = 0;
   localparam int          LPC_EV_WAKE     = 1;
   localparam int          LPC_EV_EXC      = 2;
   localparam int          LPC_EV_DBG      = 3;
   localparam logic [3:0]  LPC_EV_RST      = 4'h0;
   // Sampled pin vector layout
   localparam int          LPC_PIN_W       = 10;
   localparam int          LPC_PIN_NMI     = 6;
   localparam int          LPC_PIN_SRST    = 7;
   localparam int          LPC_PIN_CRST    = 8;
   localparam int          LPC_PIN_DINT    = 9;
   // Timer: core clock cycles per timer count
   localparam int          LPC_TIMER_W     = 32;
   localparam logic [7:0]  LPC_TIMER_DIV   = 8'h02;
endpackage
`default_nettype wire

// ===== inc/lpc_core_if.sv
// Purpose: Carries sampled pins and timer state to the control logic
// Assumes: All signals on sys_clk_in
// Notes:   Pins here are already past two flip-flops
`timescale 1ns/1ps
`default_nettype none
interface lpc_core_if;
   import lpc_pkg::*;
   logic [LPC_PIN_W-1:0]   pin;
   logic [LPC_TIMER_W-1:0] timer_count;
   logic                   timer_tick;
   modport sync_mp  (output pin);
   modport timer_mp (output timer_count, output timer_tick);
   modport ctrl_mp  (input pin, input timer_count, input timer_tick);
endinterface
`default_nettype wire

// ===== hw/lpc_sync.sv
// Purpose: Two flip-flop synchroniser for the wake and interrupt pins
// Assumes: Pins are asynchronous to sys_clk_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module lpc_sync
   import lpc_pkg::*;
(
   // Clock and reset
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_in,
   // Raw pins
   input  wire logic [LPC_PIN_W-1:0] pin_in,
   // Sampled pins
   lpc_core_if.sync_mp               core
);
   logic [LPC_PIN_W-1:0] meta_reg;
   logic [LPC_PIN_W-1:0] sync_reg;

   // One pair of flip-flops per pin
   genvar g;
   generate
      for (g = 0; g < LPC_PIN_W; g++) begin : g_bit
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
            end else begin
               meta_reg[g] <= pin_in[g];
               sync_reg[g] <= meta_reg[g];
            end
         end
      end
   endgenerate

   assign core.pin = sync_reg;
endmodule
`default_nettype wire

// ===== hw/lpc_timer.sv
// Purpose: Free-running internal timer with its own rate divider
// Assumes: Never gated; keeps counting while the core sleeps
// Notes:   timer_tick is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module lpc_timer
   import lpc_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   // Timer state
   lpc_core_if.timer_mp core
);
   logic [7:0]             div_reg;
   logic [LPC_TIMER_W-1:0] count_reg;
   logic                   tick_reg;
   wire                    div_wrap = (div_reg == LPC_TIMER_DIV - 8'h01);

   // Divider produces the tick, counter advances one cycle later
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg   <= 8'h00;
         tick_reg  <= 1'b0;
         count_reg <= 32'h0000_0000;
      end else begin
         div_reg   <= div_wrap ? 8'h00 : div_reg + 8'h01;
         tick_reg  <= div_wrap;
         if (tick_reg) begin
            count_reg <= count_reg + 32'h0000_0001;
         end
      end
   end

   assign core.timer_count = count_reg;
   assign core.timer_tick  = tick_reg;
endmodule
`default_nettype wire

// ===== hw/lpc_ctrl.sv
// Purpose: Power-management pins, wait sleep sequencing and its registers
// Assumes: wait_at_mem_in and bus_idle_in come from core logic on sys_clk_in
// Notes:   Registers on Avalon-MM; waitrequest drops one cycle after a request
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reduce_power_out mirrors status bit 27.
// - exception_level_out mirrors status bit 1.
// - error_level_out mirrors status bit 2.
// - debug_mode_out is high while in debug mode, entered on debug interrupt.
// - A taken interrupt, even asleep, sets the exception-level bit and pin.
// - Wait at memory stage with idle bus stops clocks and freezes pipeline.
// - Wait with busy bus stalls until idle, then stops clocks.
// - Timer and wake pins keep running while clocks are stopped.
// - Enabled interrupt, NMI, debug interrupt or reset ends wait sleep.
// - sleep_out stays high for the whole wait sleep.
module lpc_ctrl
   import lpc_pkg::*;
(
   // Clock and reset
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   // Register bus
   input  wire logic [LPC_ADDR_W-1:0] avs_address_in,
   input  wire logic                  avs_read_in,
   input  wire logic                  avs_write_in,
   input  wire logic [LPC_DATA_W-1:0] avs_writedata_in,
   input  wire logic [LPC_BE_W-1:0]   avs_byteenable_in,
   output logic      [LPC_DATA_W-1:0] avs_readdata_out,
   output logic                       avs_waitrequest_out,
   // Core pipeline
   input  wire logic                  wait_at_mem_in,
   input  wire logic                  bus_idle_in,
   output logic                       core_clk_en_out,
   output logic                       pipe_freeze_out,
   // Wake and interrupt pins
   input  wire logic [LPC_IM_W-1:0]   int_req_in,
   input  wire logic                  nmi_in,
   input  wire logic                  soft_reset_in,
   input  wire logic                  cold_reset_in,
   input  wire logic                  debug_interrupt_in,
   // Power-management pins
   output logic                       reduce_power_out,
   output logic                       exception_level_out,
   output logic                       error_level_out,
   output logic                       debug_mode_out,
   output logic                       sleep_out,
   // Interrupt
   output logic                       irq_out
);
   typedef enum logic [1:0] {LPC_RUN, LPC_STALL, LPC_SLEEP} lpc_state_e;

   lpc_core_if core ();

   lpc_sync u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pin_in     ({debug_interrupt_in, cold_reset_in, soft_reset_in, nmi_in, int_req_in}),
      .core       (core.sync_mp)
   );

   lpc_timer u_timer (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .core       (core.timer_mp)
   );

   lpc_state_e      state_reg;
   lpc_state_e      state_next;
   logic [31:0]     status_reg;
   logic [31:0]     status_next;
   logic            debug_reg;
   logic            debug_next;
   logic [3:0]      irq_st_reg;
   logic [3:0]      irq_st_next;
   logic [3:0]      irq_msk_reg;
   logic [3:0]      irq_msk_next;
   logic            nmi_d_reg;
   logic            dint_d_reg;
   logic            wait_reg;
   logic [31:0]     rdata_reg;
   logic            sleep_reg;
   logic            clk_en_reg;
   logic            freeze_reg;
   logic            irq_reg;

   // Bus decode; a write lands at the edge where waitrequest is seen low
   wire        bus_req  = avs_read_in | avs_write_in;
   wire        wr_go    = avs_write_in & ~wait_reg;
   wire [31:0] be_mask  = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                           {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   wire [31:0] wdata_m  = avs_writedata_in & be_mask;
   wire        wr_stat  = wr_go & (avs_address_in == LPC_OFS_STATUS);
   wire        wr_ctl   = wr_go & (avs_address_in == LPC_OFS_CONTROL);
   wire        wr_ist   = wr_go & (avs_address_in == LPC_OFS_IRQ_ST);
   wire        wr_imsk  = wr_go & (avs_address_in == LPC_OFS_IRQ_MSK);
   wire [31:0] stat_wm  = be_mask & LPC_STATUS_WMSK;

   // Wake sources from the sampled pins
   wire [LPC_IM_W-1:0] int_pend = core.pin[LPC_IM_W-1:0]
                                  & status_reg[LPC_IM_LSB +: LPC_IM_W];
   wire int_take  = (|int_pend) & status_reg[LPC_IE_BIT] & ~status_reg[LPC_EXL_BIT]
                    & ~status_reg[LPC_ERL_BIT] & ~debug_reg;
   wire nmi_rise  = core.pin[LPC_PIN_NMI] & ~nmi_d_reg;
   wire dint_rise = core.pin[LPC_PIN_DINT] & ~dint_d_reg;
   wire rst_req   = core.pin[LPC_PIN_SRST] | core.pin[LPC_PIN_CRST];
   wire err_take  = nmi_rise | rst_req;
   wire wake      = int_take | nmi_rise | dint_rise | rst_req;

   // Read selection; unmapped offsets read as zero
   wire [31:0] state_word = {6'h00, core.pin, 11'h000, clk_en_reg, bus_idle_in,
                             debug_reg, freeze_reg & ~sleep_reg, sleep_reg};
   wire [31:0] rd_mux =
      (avs_address_in == LPC_OFS_STATUS)  ? status_reg :
      (avs_address_in == LPC_OFS_STATE)   ? state_word :
      (avs_address_in == LPC_OFS_IRQ_ST)  ? {28'h0000000, irq_st_reg} :
      (avs_address_in == LPC_OFS_IRQ_MSK) ? {28'h0000000, irq_msk_reg} :
      (avs_address_in == LPC_OFS_TIMER)   ? core.timer_count : 32'h0000_0000;

   // Wait sleep sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LPC_RUN: begin
            if (wait_at_mem_in && bus_idle_in) begin
               state_next = LPC_SLEEP;
            end else if (wait_at_mem_in) begin
               state_next = LPC_STALL;
            end
         end
         LPC_STALL: begin
            if (bus_idle_in) begin
               state_next = LPC_SLEEP;
            end
         end
         LPC_SLEEP: begin
            if (wake) begin
               state_next = LPC_RUN;
            end
         end
         default: state_next = LPC_RUN;
      endcase
   end

   // Status register: software write, then hardware sets win
   always_comb begin
      status_next = status_reg;
      if (wr_stat) begin
         status_next = (status_reg & ~stat_wm) | (wdata_m & stat_wm);
      end
      if (wr_ctl && wdata_m[LPC_CTL_EXC_RET]) begin
         status_next[LPC_EXL_BIT] = 1'b0;
      end
      if (int_take) begin
         status_next[LPC_EXL_BIT] = 1'b1;
      end
      if (err_take) begin
         status_next[LPC_ERL_BIT] = 1'b1;
      end
      if (rst_req) begin
         status_next[LPC_RP_BIT] = 1'b0;
      end
   end

   // Debug mode: entry wins over a return in the same cycle
   assign debug_next = dint_rise | (debug_reg & ~(wr_ctl & wdata_m[LPC_CTL_DBG_RET]));

   // Sticky events, write one to clear, set wins over clear
   wire [3:0] ev_set = {dint_rise & ~debug_reg, int_take,
                        (state_reg == LPC_SLEEP) & wake,
                        (state_reg != LPC_SLEEP) & (state_next == LPC_SLEEP)};
   assign irq_st_next  = (irq_st_reg & ~(wr_ist ? wdata_m[3:0] : 4'h0)) | ev_set;
   assign irq_msk_next = wr_imsk ? wdata_m[3:0] : irq_msk_reg;

   // Control state and interrupt registers
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg   <= LPC_RUN;
         status_reg  <= LPC_STATUS_RST;
         debug_reg   <= 1'b0;
         irq_st_reg  <= LPC_EV_RST;
         irq_msk_reg <= LPC_EV_RST;
         irq_reg     <= 1'b0;
         nmi_d_reg   <= 1'b0;
         dint_d_reg  <= 1'b0;
      end else begin
         state_reg   <= state_next;
         status_reg  <= status_next;
         debug_reg   <= debug_next;
         irq_st_reg  <= irq_st_next;
         irq_msk_reg <= irq_msk_next;
         irq_reg     <= |(irq_st_next & irq_msk_next);
         nmi_d_reg   <= core.pin[LPC_PIN_NMI];
         dint_d_reg  <= core.pin[LPC_PIN_DINT];
      end
   end

   // Clock gate and sleep flags switch on the same edge; freeze rises already on entry to the stall
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sleep_reg  <= 1'b0;
         clk_en_reg <= 1'b1;
         freeze_reg <= 1'b0;
      end else begin
         sleep_reg  <= (state_next == LPC_SLEEP);
         clk_en_reg <= (state_next != LPC_SLEEP);
         freeze_reg <= (state_next != LPC_RUN);
      end
   end

   // Bus answer: waitrequest low for one cycle after a request is seen
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         wait_reg <= ~(bus_req & wait_reg);
         if (bus_req && wait_reg) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   // Pins straight from flip-flops
   assign reduce_power_out    = status_reg[LPC_RP_BIT];
   assign exception_level_out = status_reg[LPC_EXL_BIT];
   assign error_level_out     = status_reg[LPC_ERL_BIT];
   assign debug_mode_out      = debug_reg;
   assign sleep_out           = sleep_reg;
   assign core_clk_en_out     = clk_en_reg;
   assign pipe_freeze_out     = freeze_reg;
   assign irq_out             = irq_reg;
   assign avs_readdata_out    = rdata_reg;
   assign avs_waitrequest_out = wait_reg;

   // Checks on the block's own behaviour
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_wait_busy;
      (state_reg == LPC_RUN) && wait_at_mem_in && !bus_idle_in;
   endsequence

   sequence s_stalled;
      pipe_freeze_out && !sleep_out && core_clk_en_out;
   endsequence

   property p_rp_follow;
      (wr_stat && stat_wm[LPC_RP_BIT] && !rst_req)
         |=> (reduce_power_out == $past(avs_writedata_in[LPC_RP_BIT]));
   endproperty
   a_rp_follow: assert property (p_rp_follow) else $error("reduce power pin off its bit");

   property p_exl_clear;
      (wr_stat && stat_wm[LPC_EXL_BIT] && !avs_writedata_in[LPC_EXL_BIT] && !int_take)
         |=> !exception_level_out;
   endproperty
   a_exl_clear: assert property (p_exl_clear) else $error("exception pin not cleared");

   property p_erl_set;
      err_take |=> error_level_out;
   endproperty
   a_erl_set: assert property (p_erl_set) else $error("error pin not set");

   property p_dbg_enter;
      dint_rise |=> debug_mode_out ##1 (debug_mode_out || $past(wr_ctl));
   endproperty
   a_dbg_enter: assert property (p_dbg_enter) else $error("debug pin not held");

   property p_exl_on_int;
      (int_take && sleep_out) |=> exception_level_out && !sleep_out;
   endproperty
   a_exl_on_int: assert property (p_exl_on_int) else $error("interrupt while asleep lost");

   property p_idle_sleep;
      ((state_reg == LPC_RUN) && wait_at_mem_in && bus_idle_in)
         |=> sleep_out && !core_clk_en_out && pipe_freeze_out;
   endproperty
   a_idle_sleep: assert property (p_idle_sleep) else $error("idle wait did not sleep");

   property p_busy_stall;
      s_wait_busy ##1 (!bus_idle_in)[*2] |-> s_stalled ##1 s_stalled;
   endproperty
   a_busy_stall: assert property (p_busy_stall) else $error("busy wait slept early");

   property p_timer_runs;
      (sleep_out && core.timer_tick) |=> core.timer_count == $past(core.timer_count) + 32'h0000_0001;
   endproperty
   a_timer_runs: assert property (p_timer_runs) else $error("timer stopped in sleep");

   property p_wake;
      (state_reg == LPC_SLEEP && wake) |=> !sleep_out && core_clk_en_out && !pipe_freeze_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake source ignored");

   property p_sleep_hold;
      (sleep_out && !wake) |=> sleep_out && !core_clk_en_out;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep dropped without wake");

   property p_sleep_fall;
      $fell(sleep_out) |-> core_clk_en_out && $rose(core_clk_en_out);
   endproperty
   a_sleep_fall: assert property (p_sleep_fall) else $error("sleep fell apart from clock restart");

   property p_exl_set;
      int_take |=> exception_level_out;
   endproperty
   a_exl_set: assert property (p_exl_set) else $error("taken interrupt left exception pin low");

   property p_dbg_exit;
      (debug_mode_out && wr_ctl && wdata_m[LPC_CTL_DBG_RET] && !dint_rise) |=> !debug_mode_out;
   endproperty
   a_dbg_exit: assert property (p_dbg_exit) else $error("debug mode not left");

   property p_erl_clear;
      (wr_stat && stat_wm[LPC_ERL_BIT] && !avs_writedata_in[LPC_ERL_BIT] && !err_take)
         |=> !error_level_out;
   endproperty
   a_erl_clear: assert property (p_erl_clear) else $error("error pin not cleared");

   property p_stall_sleep;
      (state_reg == LPC_STALL && bus_idle_in) |=> sleep_out && !core_clk_en_out;
   endproperty
   a_stall_sleep: assert property (p_stall_sleep) else $error("stall did not end in sleep");

   property p_pin_sample;
      sleep_out |=> core.pin == $past(u_sync.meta_reg);
   endproperty
   a_pin_sample: assert property (p_pin_sample) else $error("wake pins frozen in sleep");

   property p_wake_reset;
      (sleep_out && rst_req) |=> !sleep_out && core_clk_en_out;
   endproperty
   a_wake_reset: assert property (p_wake_reset) else $error("reset level did not wake");

   property p_sleep_rise;
      $rose(sleep_out) |-> pipe_freeze_out && !core_clk_en_out;
   endproperty
   a_sleep_rise: assert property (p_sleep_rise) else $error("sleep rose apart from clock stop");

   property p_clk_restart;
      $rose(core_clk_en_out) |-> $fell(sleep_out) && !pipe_freeze_out;
   endproperty
   a_clk_restart: assert property (p_clk_restart) else $error("clock restart apart from wake");
endmodule
`default_nettype wire

// ===== test/lpc_agent.sv
// Purpose: Behavioural clock agent facing the power-management pins
// Assumes: Same clock as the block under test
// Notes:   Only chooses slow or full-speed core clocking; drives nothing back
`timescale 1ns/1ps
`default_nettype none
module lpc_agent #(
   parameter bit FAST_SERVICE = 1'b1
) (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   // Pins watched
   input  wire logic reduce_power_in,
   input  wire logic exception_level_in,
   input  wire logic error_level_in,
   input  wire logic debug_mode_in,
   // Clock choice
   output logic      slow_clk_out
);
   logic urgent;
   // Exception, error or debug work may want full speed
   assign urgent = exception_level_in | error_level_in | debug_mode_in;
   // Slow the core on reduce power unless urgent work is pending
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         slow_clk_out <= 1'b0;
      end else begin
         slow_clk_out <= reduce_power_in & ~(FAST_SERVICE & urgent);
      end
   end
endmodule
`default_nettype wire

// ===== test/lpc_ctrl_bench.sv
// Purpose: Self-checking bench for the low power control block
// Assumes: One clock; registers reached over Avalon-MM
// Notes:   Integer model of status and event bits is compared at every read of those registers
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl_bench
   import lpc_pkg::*;
;
   logic        sys_clk_in, rst_in, avs_read_in, avs_write_in;
   logic [4:0]  avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic [3:0]  avs_byteenable_in, be;
   logic        avs_waitrequest_out, wait_at_mem_in, bus_idle_in, core_clk_en_out, pipe_freeze_out;
   logic [5:0]  int_req_in;
   logic        nmi_in, soft_reset_in, cold_reset_in, debug_interrupt_in;
   logic        reduce_power_out, exception_level_out, error_level_out, debug_mode_out;
   logic        sleep_out, irq_out, slow_clk;
   int          fail_count, total_checks, cyc, n, src;
   logic [31:0] st_m, ist_m, rd, t1, bm, d;
   int          src_q[$];

   lpc_ctrl lpc_ctrl_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .wait_at_mem_in(wait_at_mem_in), .bus_idle_in(bus_idle_in),
      .core_clk_en_out(core_clk_en_out), .pipe_freeze_out(pipe_freeze_out), .int_req_in(int_req_in),
      .nmi_in(nmi_in), .soft_reset_in(soft_reset_in), .cold_reset_in(cold_reset_in),
      .debug_interrupt_in(debug_interrupt_in), .reduce_power_out(reduce_power_out),
      .exception_level_out(exception_level_out), .error_level_out(error_level_out),
      .debug_mode_out(debug_mode_out), .sleep_out(sleep_out), .irq_out(irq_out));

   lpc_agent lpc_agent_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reduce_power_in(reduce_power_out),
      .exception_level_in(exception_level_out), .error_level_in(error_level_out),
      .debug_mode_in(debug_mode_out), .slow_clk_out(slow_clk));

   // Free-running 100 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   // Cuts a hang short
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end

   // Counts and reports one comparison
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One Avalon-MM access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dt, input logic [3:0] b);
      @(posedge sys_clk_in);
      avs_address_in    <= a;
      avs_writedata_in  <= dt;
      avs_byteenable_in <= b;
      avs_read_in       <= ~wr;
      avs_write_in      <= wr;
      do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] dt);
      bus(1'b1, a, dt, 4'hF);
   endtask

   task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      check(nm, rd, exp);
   endtask

   // Pins follow the modelled status word
   task automatic pin_chk();
      check("rp_pin", reduce_power_out, st_m[LPC_RP_BIT]);
      check("exl_pin", exception_level_out, st_m[LPC_EXL_BIT]);
      check("erl_pin", error_level_out, st_m[LPC_ERL_BIT]);
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'hD7EA3DE7));
      {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, avs_byteenable_in} = '0;
      {wait_at_mem_in, int_req_in, nmi_in, soft_reset_in, cold_reset_in, debug_interrupt_in} = '0;
      bus_idle_in = 1'b1;
      rst_in      = 1'b1;
      cyc         = 0;
      st_m        = LPC_STATUS_RST;
      repeat (3) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(negedge sys_clk_in);
      pin_chk();
      check("dbg_pin", debug_mode_out, 1'b0);
      check("sleep_rst", {sleep_out, core_clk_en_out}, 2'b01);
      rd_chk("status_rst", LPC_OFS_STATUS, LPC_STATUS_RST);
      // Unmapped place and write-only control read back zero
      wr(5'h18, $urandom);
      rd_chk("unmapped", 5'h18, 32'h0);
      rd_chk("control", LPC_OFS_CONTROL, 32'h0);
      rd_chk("status_kept", LPC_OFS_STATUS, st_m);
      // Random status writes with random byte lanes
      for (int i = 0; i < 8; i++) begin
         d  = $urandom;
         be = 4'($urandom_range(1, 15));
         for (int b = 0; b < 4; b++) bm[8*b+:8] = {8{be[b]}};
         bus(1'b1, LPC_OFS_STATUS, d, be);
         st_m = (st_m & ~(bm & LPC_STATUS_WMSK)) | (d & bm & LPC_STATUS_WMSK);
         rd_chk("status_rw", LPC_OFS_STATUS, st_m);
         repeat (3) @(negedge sys_clk_in);
         pin_chk();
         check("agent", slow_clk, st_m[27] & ~(st_m[1] | st_m[2]));
      end
      // Sleep and wake by each source: interrupt, nmi, soft, cold, debug
      src_q = '{0, 1, 2, 3, 4};
      st_m  = 32'h0800_3F01;
      wr(LPC_OFS_STATUS, st_m);
      wr(LPC_OFS_IRQ_ST, 32'hF);
      foreach (src_q[k]) begin
         src = src_q[k];
         wr(LPC_OFS_IRQ_MSK, (src == 2) ? 32'h0 : 32'hF);
         @(posedge sys_clk_in);
         bus_idle_in    <= (src != 1);
         wait_at_mem_in <= 1'b1;
         @(posedge sys_clk_in);
         wait_at_mem_in <= 1'b0;
         @(negedge sys_clk_in);
         if (src == 1) begin
            repeat (3) @(negedge sys_clk_in);
            check("stall", {sleep_out, pipe_freeze_out, core_clk_en_out}, 3'b011);
            rd_chk("state_stall", LPC_OFS_STATE, 32'h0000_0012);
            @(posedge sys_clk_in);
            bus_idle_in <= 1'b1;
            repeat (3) @(negedge sys_clk_in);
         end
         check("asleep", {sleep_out, pipe_freeze_out, core_clk_en_out}, 3'b110);
         repeat (2) @(negedge sys_clk_in);
         check("irq_sleep", irq_out, src != 2);
         bus(1'b0, LPC_OFS_TIMER, 32'h0, 4'hF);
         t1 = rd;
         repeat (10) @(negedge sys_clk_in);
         bus(1'b0, LPC_OFS_TIMER, 32'h0, 4'hF);
         check("timer_run", rd - t1, 32'(12 / LPC_TIMER_DIV)); // captures lie 12 cycles apart
         check("still_asleep", sleep_out, 1'b1);
         @(posedge sys_clk_in);
         case (src)
            0: int_req_in <= 6'($urandom_range(1, 63));
            1: nmi_in <= 1'b1;
            2: soft_reset_in <= 1'b1;
            3: cold_reset_in <= 1'b1;
            default: debug_interrupt_in <= 1'b1;
         endcase
         n = 0;
         while (sleep_out !== 1'b0 && n < 8) begin
            @(negedge sys_clk_in);
            n++;
         end
         check("wake_lat", n <= 5, 1'b1);
         check("awake", {pipe_freeze_out, core_clk_en_out}, 2'b01);
         repeat (2) @(negedge sys_clk_in);
         st_m[LPC_EXL_BIT] = (src == 0);
         st_m[LPC_ERL_BIT] = (src >= 1 && src <= 3);
         st_m[LPC_RP_BIT]  = !(src == 2 || src == 3);
         pin_chk();
         check("dbg_wake", debug_mode_out, src == 4);
         ist_m = 32'h3 | ((src == 0) ? 32'h4 : 32'h0) | ((src == 4) ? 32'h8 : 32'h0);
         rd_chk("irq_st", LPC_OFS_IRQ_ST, ist_m);
         @(posedge sys_clk_in);
         {int_req_in, nmi_in, soft_reset_in, cold_reset_in, debug_interrupt_in} <= '0;
         repeat (4) @(negedge sys_clk_in);
         wr(LPC_OFS_CONTROL, 32'h3);
         st_m = 32'h0800_3F01;
         wr(LPC_OFS_STATUS, st_m);
         wr(LPC_OFS_IRQ_ST, 32'hF);
         rd_chk("irq_clr", LPC_OFS_IRQ_ST, 32'h0);
         repeat (2) @(negedge sys_clk_in);
         check("irq_low", irq_out, 1'b0);
         check("dbg_left", debug_mode_out, 1'b0);
         pin_chk();
      end
      finish_test();
   end
endmodule
`default_nettype wire
